// [hw/cie_regs.svh]
// register offsets, status bit positions and reset values of the execute unit
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH

// register offsets on the plain register port
`define CIE_ADR_CMD 8'h00
`define CIE_ADR_MADDR 8'h01
`define CIE_ADR_IMM 8'h02
`define CIE_ADR_WORK 8'h03
`define CIE_ADR_STATUS 8'h04
`define CIE_ADR_PC 8'h05
`define CIE_ADR_STACK 8'h06
`define CIE_ADR_SP 8'h07

// status register bit positions
`define CIE_ST_ZERO 0
`define CIE_ST_CARRY 1
`define CIE_ST_PDF 2
`define CIE_ST_TO 3
`define CIE_ST_GIE 4
`define CIE_ST_BUSY 5
`define CIE_ST_HALT 6
`define CIE_ST_DROP 7

// reset values
`define CIE_RST_WORK 8'h00
`define CIE_RST_PC 13'h0000
`define CIE_RST_IMM 13'h0000
`define CIE_RST_MADDR 8'h00
`define CIE_RST_FLAG 1'b0
`define CIE_RST_CLK_EN 1'b1

// step of the program counter and of the operand arithmetic
`define CIE_PC_STEP 13'h0001
`define CIE_ONE 8'h01

`endif

// [hw/cie_pkg.sv]
// types shared by the execute unit files
package cie_pkg;

    // instruction selector written to the command register
    typedef enum logic [4:0] {
        OP_NOP,
        OP_SUB1_MEM,
        OP_SUB1_WORK,
        OP_ADD1_MEM,
        OP_ADD1_WORK,
        OP_JUMP,
        OP_COPY_M2W,
        OP_COPY_X2W,
        OP_COPY_W2M,
        OP_OR_MW,
        OP_OR_XW,
        OP_OR_INTO_MEM,
        OP_SUB_EXIT,
        OP_SUB_EXIT_X,
        OP_IRQ_EXIT,
        OP_ROT_L,
        OP_ROT_L_COPY,
        OP_ROT_LC,
        OP_ROT_LC_COPY,
        OP_ROT_R,
        OP_ROT_R_COPY,
        OP_ROT_RC,
        OP_ROT_RC_COPY,
        OP_POWER_DOWN
    } cie_op_t;

    // execution sequence states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_EXEC,
        ST_DUMMY
    } cie_state_t;

endpackage

// [hw/cie_mem_if.sv]
// data memory port between the execute unit and its memory
`timescale 1ns/10ps
interface cie_mem_if #(
    parameter int ADDR_W = 8
);
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    logic re;

    modport ctrl (output addr, output wdata, output we, output re, input rdata);
    modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface

// [hw/cie_dmem.sv]
// byte-wide data memory with registered read data
`timescale 1ns/10ps
module cie_dmem #(
    parameter int ADDR_W = 8,
    parameter int DEPTH = 256
)(
    input wire logic i_clk, // core clock
    input wire logic i_arst_n, // async reset, active low
    cie_mem_if.mem bus // memory port
);
    logic [7:0] store [DEPTH];

    // array write, kept free of reset
    always_ff @(posedge i_clk)
    begin
        if (bus.we)
        begin
            store[bus.addr] <= bus.wdata;
        end
    end

    // registered read data
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            bus.rdata <= 8'h00;
        end
        else if (bus.re)
        begin
            bus.rdata <= store[bus.addr];
        end
    end
endmodule // cie_dmem

// [hw/cie_exec.sv]
// execute unit for a subset of the 8-bit core instruction set
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "cie_regs.svh"

module cie_exec #(
    parameter int ADDR_W = 8,
    parameter int PC_W = 13,
    parameter int STACK_DEPTH = 8,
    parameter logic [12:0] IRQ_VECTOR = 13'h0004
)(
    input wire logic i_clk, // core clock, 40 MHz
    input wire logic i_arst_n, // async reset, active low
    input wire logic [7:0] i_reg_addr, // register address
    input wire logic [15:0] i_reg_wdata, // register write data
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    output logic [15:0] o_reg_rdata, // read data, cycle after strobe
    input wire logic i_irq_pending, // interrupt request waiting
    input wire logic i_wake, // wake-up event from power down
    input wire logic i_wdt_timeout, // watchdog timeout event
    output logic o_irq_ack, // pulse: pending interrupt entered
    output logic o_wdt_clear, // pulse: clear watchdog and prescaler
    output logic o_sys_clk_en, // system clock enable, low in power down
    output logic [PC_W-1:0] o_pc, // program counter
    output logic o_busy // instruction in progress
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    cie_mem_if #(.ADDR_W(ADDR_W)) mbus ();

    cie_pkg::cie_state_t state;
    cie_pkg::cie_op_t op;
    logic [ADDR_W-1:0] maddr;
    logic [12:0] imm;
    logic [7:0] work;
    logic flag_z, flag_c, power_down_flag, wdt_to, gie, halted, dropped;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [15:0] rd_mux;

    // zero detection shared by every instruction that updates the zero flag
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    // instructions that take the extra dummy cycle
    function automatic logic is_branch(input cie_pkg::cie_op_t o);
        return (o == cie_pkg::OP_JUMP) || (o == cie_pkg::OP_SUB_EXIT) ||
               (o == cie_pkg::OP_SUB_EXIT_X) || (o == cie_pkg::OP_IRQ_EXIT);
    endfunction

    // instructions that pop the return stack
    function automatic logic is_pop(input cie_pkg::cie_op_t o);
        return (o == cie_pkg::OP_SUB_EXIT) || (o == cie_pkg::OP_SUB_EXIT_X) ||
               (o == cie_pkg::OP_IRQ_EXIT);
    endfunction

    // register port decode
    wire sel_cmd = (i_reg_addr == `CIE_ADR_CMD);
    wire idle = (state == cie_pkg::ST_IDLE);
    wire wr_ok = i_reg_wr && idle && !halted;
    wire cmd_take = wr_ok && sel_cmd;
    wire wr_refused = i_reg_wr && !wr_ok;
    wire sw_maddr = wr_ok && (i_reg_addr == `CIE_ADR_MADDR);
    wire sw_imm = wr_ok && (i_reg_addr == `CIE_ADR_IMM);
    wire sw_work = wr_ok && (i_reg_addr == `CIE_ADR_WORK);
    wire sw_status = wr_ok && (i_reg_addr == `CIE_ADR_STATUS);
    wire sw_pc = wr_ok && (i_reg_addr == `CIE_ADR_PC);
    wire sw_push = wr_ok && (i_reg_addr == `CIE_ADR_STACK);
    wire in_exec = (state == cie_pkg::ST_EXEC);
    wire in_dummy = (state == cie_pkg::ST_DUMMY);

    // operand and candidate results
    wire [7:0] opnd = mbus.rdata;
    wire [7:0] res_sub1 = opnd - `CIE_ONE;
    wire [7:0] res_add1 = opnd + `CIE_ONE;
    wire [7:0] res_or_m = work | opnd;
    wire [7:0] res_or_x = work | imm[7:0];
    wire [7:0] res_rl = {opnd[6:0], opnd[7]};
    wire [7:0] res_rlc = {opnd[6:0], flag_c};
    wire [7:0] res_rr = {opnd[0], opnd[7:1]};
    wire [7:0] res_rrc = {flag_c, opnd[7:1]};
    wire [PC_W-1:0] pc_next_seq = pc + PC_W'(`CIE_PC_STEP);
    wire [PC_W-1:0] stack_top = stack[sp - SP_W'(1)];
    wire irq_take = in_dummy && (op == cie_pkg::OP_IRQ_EXIT) && i_irq_pending;

    // per-instruction result selection and write enables
    logic [7:0] result;
    logic to_work, to_mem, upd_z, upd_c, new_c;
    always_comb
    begin
        result = opnd;
        to_work = 1'b0;
        to_mem = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        new_c = flag_c;
        case (op)
            cie_pkg::OP_SUB1_MEM:
            begin
                result = res_sub1;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_SUB1_WORK:
            begin
                result = res_sub1;
                to_work = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_ADD1_MEM:
            begin
                result = res_add1;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_ADD1_WORK:
            begin
                result = res_add1;
                to_work = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_COPY_M2W:
            begin
                result = opnd;
                to_work = 1'b1;
            end
            cie_pkg::OP_COPY_X2W:
            begin
                result = imm[7:0];
                to_work = 1'b1;
            end
            cie_pkg::OP_COPY_W2M:
            begin
                result = work;
                to_mem = 1'b1;
            end
            cie_pkg::OP_OR_MW:
            begin
                result = res_or_m;
                to_work = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_OR_XW:
            begin
                result = res_or_x;
                to_work = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_OR_INTO_MEM:
            begin
                result = res_or_m;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            cie_pkg::OP_SUB_EXIT_X:
            begin
                result = imm[7:0];
                to_work = 1'b1;
            end
            cie_pkg::OP_ROT_L:
            begin
                result = res_rl;
                to_mem = 1'b1;
            end
            cie_pkg::OP_ROT_L_COPY:
            begin
                result = res_rl;
                to_work = 1'b1;
            end
            cie_pkg::OP_ROT_LC:
            begin
                result = res_rlc;
                to_mem = 1'b1;
                upd_c = 1'b1;
                new_c = opnd[7];
            end
            cie_pkg::OP_ROT_LC_COPY:
            begin
                result = res_rlc;
                to_work = 1'b1;
                upd_c = 1'b1;
                new_c = opnd[7];
            end
            cie_pkg::OP_ROT_R:
            begin
                result = res_rr;
                to_mem = 1'b1;
            end
            cie_pkg::OP_ROT_R_COPY:
            begin
                result = res_rr;
                to_work = 1'b1;
            end
            cie_pkg::OP_ROT_RC:
            begin
                result = res_rrc;
                to_mem = 1'b1;
                upd_c = 1'b1;
                new_c = opnd[0];
            end
            cie_pkg::OP_ROT_RC_COPY:
            begin
                result = res_rrc;
                to_work = 1'b1;
                upd_c = 1'b1;
                new_c = opnd[0];
            end
            default:
            begin
                result = opnd;
            end
        endcase
    end

    // memory port: read in read state, write back in execute state
    assign mbus.addr = maddr;
    assign mbus.re = (state == cie_pkg::ST_READ);
    assign mbus.we = in_exec && to_mem;
    assign mbus.wdata = result;

    cie_dmem #(.ADDR_W(ADDR_W), .DEPTH(1 << ADDR_W)) u_dmem (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .bus(mbus.mem)
    );

    // execution sequence
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= cie_pkg::ST_IDLE;
            op <= cie_pkg::OP_NOP;
        end
        else
        begin
            case (state)
                cie_pkg::ST_IDLE:
                begin
                    if (cmd_take)
                    begin
                        op <= cie_pkg::cie_op_t'(i_reg_wdata[4:0]);
                        state <= cie_pkg::ST_READ;
                    end
                end
                cie_pkg::ST_READ:
                    state <= cie_pkg::ST_EXEC;
                cie_pkg::ST_EXEC:
                    state <= is_branch(op) ? cie_pkg::ST_DUMMY : cie_pkg::ST_IDLE;
                default:
                    state <= cie_pkg::ST_IDLE;
            endcase
        end
    end

    // operand address, immediate and working register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            maddr <= `CIE_RST_MADDR;
            imm <= `CIE_RST_IMM;
            work <= `CIE_RST_WORK;
        end
        else
        begin
            if (sw_maddr)
                maddr <= i_reg_wdata[ADDR_W-1:0];
            if (sw_imm)
                imm <= i_reg_wdata[12:0];
            if (in_exec && to_work)
                work <= result;
            else if (sw_work)
                work <= i_reg_wdata[7:0];
        end
    end

    // zero and carry flags
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            flag_z <= `CIE_RST_FLAG;
            flag_c <= `CIE_RST_FLAG;
        end
        else
        begin
            if (in_exec && upd_z)
                flag_z <= is_zero(result);
            else if (sw_status)
                flag_z <= i_reg_wdata[`CIE_ST_ZERO];
            if (in_exec && upd_c)
                flag_c <= new_c;
            else if (sw_status)
                flag_c <= i_reg_wdata[`CIE_ST_CARRY];
        end
    end

    // program counter and return stack
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pc <= `CIE_RST_PC;
            sp <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack[i] <= `CIE_RST_PC;
        end
        else if (in_exec)
        begin
            if (op == cie_pkg::OP_JUMP)
                pc <= imm[PC_W-1:0];
            else if (is_pop(op))
            begin
                pc <= stack_top;
                sp <= sp - SP_W'(1);
            end
            else
                pc <= pc_next_seq;
        end
        else if (irq_take)
        begin
            stack[sp] <= pc;
            sp <= sp + SP_W'(1);
            pc <= IRQ_VECTOR[PC_W-1:0];
        end
        else if (sw_push)
        begin
            stack[sp] <= i_reg_wdata[PC_W-1:0];
            sp <= sp + SP_W'(1);
        end
        else if (sw_pc)
            pc <= i_reg_wdata[PC_W-1:0];
    end

    // power down, watchdog flags, interrupt enable, refused writes
    wire do_halt = in_exec && (op == cie_pkg::OP_POWER_DOWN);
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            halted <= `CIE_RST_FLAG;
            o_sys_clk_en <= `CIE_RST_CLK_EN;
            o_wdt_clear <= `CIE_RST_FLAG;
            power_down_flag <= `CIE_RST_FLAG;
            wdt_to <= `CIE_RST_FLAG;
            gie <= `CIE_RST_FLAG;
            dropped <= `CIE_RST_FLAG;
            o_irq_ack <= `CIE_RST_FLAG;
        end
        else
        begin
            o_wdt_clear <= do_halt;
            if (do_halt)
            begin
                halted <= 1'b1;
                o_sys_clk_en <= 1'b0;
                power_down_flag <= 1'b1;
            end
            else if (halted && i_wake)
            begin
                halted <= 1'b0;
                o_sys_clk_en <= 1'b1;
            end
            // timeout event wins over the power-down clear
            if (i_wdt_timeout)
                wdt_to <= 1'b1;
            else if (do_halt)
                wdt_to <= 1'b0;
            if (in_exec && (op == cie_pkg::OP_IRQ_EXIT))
                gie <= 1'b1;
            else if (irq_take)
                gie <= 1'b0;
            else if (sw_status)
                gie <= i_reg_wdata[`CIE_ST_GIE];
            o_irq_ack <= irq_take;
            if (wr_refused)
                dropped <= 1'b1;
            else if (sw_status && i_reg_wdata[`CIE_ST_DROP])
                dropped <= 1'b0;
        end
    end

    // read selection
    always_comb
    begin
        rd_mux = 16'h0000;
        case (i_reg_addr)
            `CIE_ADR_MADDR: rd_mux = 16'(maddr);
            `CIE_ADR_IMM: rd_mux = 16'(imm);
            `CIE_ADR_WORK: rd_mux = 16'(work);
            `CIE_ADR_STATUS: rd_mux = {8'h00, dropped, halted, !idle, gie, wdt_to, power_down_flag,
                                       flag_c, flag_z};
            `CIE_ADR_PC: rd_mux = 16'(pc);
            `CIE_ADR_STACK: rd_mux = 16'(stack_top);
            `CIE_ADR_SP: rd_mux = 16'(sp);
            default: rd_mux = 16'h0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_reg_rdata <= 16'h0000;
        else
            o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
    end

    assign o_pc = pc;
    assign o_busy = !idle;
endmodule // cie_exec

// [testbench/cie_exec_asserts.sv]
// port checker of the execute unit, bound to its top module
`timescale 1ns/10ps
`include "cie_regs.svh"
module cie_exec_asserts #(
    parameter int PC_W = 13,
    parameter logic [12:0] IRQ_VECTOR = 13'h0004
)(
    input wire logic i_clk, // core clock
    input wire logic i_arst_n, // async reset, active low
    input wire logic [7:0] i_reg_addr, // register address
    input wire logic [15:0] i_reg_wdata, // write data
    input wire logic i_reg_wr, // write strobe
    input wire logic i_reg_rd, // read strobe
    input wire logic [15:0] o_reg_rdata, // read data
    input wire logic i_irq_pending, // interrupt waiting
    input wire logic i_wake, // wake event
    input wire logic i_wdt_timeout, // timeout event
    input wire logic o_irq_ack, // interrupt entered
    input wire logic o_wdt_clear, // watchdog clear pulse
    input wire logic o_sys_clk_en, // clock enable
    input wire logic [PC_W-1:0] o_pc, // program counter
    input wire logic o_busy // instruction running
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [12:0] imm_q;
    // command accepted while idle and running
    wire acc_ok = i_reg_wr && !o_busy && o_sys_clk_en;
    wire cmd_go = acc_ok && (i_reg_addr == `CIE_ADR_CMD);
    wire [4:0] cmd_op = i_reg_wdata[4:0];
    // shadow of the immediate register for the jump target
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            imm_q <= 13'h0000;
        else if (acc_ok && (i_reg_addr == `CIE_ADR_IMM))
            imm_q <= i_reg_wdata[12:0];
    end
    AST_JUMP_BUSY: assert property (
        cmd_go && cmd_op == 5'h05 |-> ##1 o_busy [*3] ##1 !o_busy)
        else $error("jump busy length wrong");
    AST_JUMP_PC: assert property (cmd_go && cmd_op == 5'h05 |-> ##3 o_pc == imm_q)
        else $error("jump target not loaded");
    AST_NOP_STEP: assert property (cmd_go && cmd_op == 5'h00 |-> ##1 o_busy [*2]
        ##1 (!o_busy && o_pc == $past(o_pc, 3) + 1'b1)) else $error("nop step wrong");
    AST_HALT_CLK: assert property (cmd_go && cmd_op == 5'h17 |-> ##3 !o_sys_clk_en)
        else $error("clock not gated in power down");
    AST_HALT_WDT: assert property (cmd_go && cmd_op == 5'h17 |-> ##[3:4] o_wdt_clear)
        else $error("watchdog not cleared");
    AST_HALT_HOLD: assert property (
        !o_sys_clk_en && !i_wake |=> !o_sys_clk_en && !o_busy)
        else $error("execution while halted");
    AST_WAKE: assert property (!o_sys_clk_en && i_wake |=> o_sys_clk_en)
        else $error("no wake from power down");
    AST_IRQ_ACK: assert property (
        cmd_go && cmd_op == 5'h0e ##3 i_irq_pending |=> o_irq_ack && o_pc == IRQ_VECTOR)
        else $error("pending interrupt not entered");
    AST_IRQ_NOACK: assert property (
        cmd_go && cmd_op == 5'h0e ##3 !i_irq_pending |=> !o_irq_ack)
        else $error("interrupt entered without request");
    // main scenarios reached
    COV_JUMP: cover property (cmd_go && cmd_op == 5'h05);
    COV_ACK: cover property (o_irq_ack);
    COV_HALT: cover property ($fell(o_sys_clk_en));
endmodule // cie_exec_asserts

bind cie_exec cie_exec_asserts #(.PC_W(PC_W), .IRQ_VECTOR(IRQ_VECTOR)) i_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_irq_pending(i_irq_pending), .i_wake(i_wake), .i_wdt_timeout(i_wdt_timeout),
    .o_irq_ack(o_irq_ack), .o_wdt_clear(o_wdt_clear), .o_sys_clk_en(o_sys_clk_en),
    .o_pc(o_pc), .o_busy(o_busy));

// [testbench/tb.sv]
// self-checking bench of the execute unit
`timescale 1ns/10ps
`include "cie_regs.svh"
module tb;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_irq_pending = 1'b0;
    logic i_wake = 1'b0;
    logic i_wdt_timeout = 1'b0;
    logic [15:0] o_reg_rdata;
    logic o_irq_ack, o_wdt_clear, o_sys_clk_en, o_busy;
    logic [12:0] o_pc;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'hf0e8d48c;
    logic [31:0] r;
    logic [4:0] op_tab [18] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
        5'h0b, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};
    cie_exec i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_irq_pending(i_irq_pending), .i_wake(i_wake),
        .i_wdt_timeout(i_wdt_timeout), .o_irq_ack(o_irq_ack), .o_wdt_clear(o_wdt_clear),
        .o_sys_clk_en(o_sys_clk_en), .o_pc(o_pc), .o_busy(o_busy));
    // 40 MHz core clock
    always #12.5 i_clk = ~i_clk;
    // xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {memory, working, zero, carry} after a data op
    function automatic logic [17:0] model(input logic [4:0] o, input logic [7:0] mv, wv, xv,
        input logic c, z);
        logic [7:0] v;
        logic md;
        case (o)
            5'h01, 5'h02: v = mv - 8'h01;
            5'h03, 5'h04: v = mv + 8'h01;
            5'h06: v = mv;
            5'h07: v = xv;
            5'h08: v = wv;
            5'h09, 5'h0b: v = wv | mv;
            5'h0a: v = wv | xv;
            5'h0f, 5'h10: v = {mv[6:0], mv[7]};
            5'h11, 5'h12: v = {mv[6:0], c};
            5'h13, 5'h14: v = {mv[0], mv[7:1]};
            default: v = {c, mv[7:1]};
        endcase
        md = o inside {5'h01, 5'h03, 5'h08, 5'h0b, 5'h0f, 5'h11, 5'h13, 5'h15};
        return {md ? v : mv, md ? wv : v,
            (o inside {[5'h01:5'h04], [5'h09:5'h0b]}) ? (v == 8'h00) : z,
            (o inside {5'h11, 5'h12}) ? mv[7] : ((o inside {5'h15, 5'h16}) ? mv[0] : c)};
    endfunction
    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= v;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, exp);
    endtask
    // bounded wait for the unit to go idle
    task automatic idle_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            #1 n++;
        end while (o_busy !== 1'b0 && n < 8);
        if (n >= 8)
        begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic run(input logic [4:0] o);
        wr(`CIE_ADR_CMD, {11'h000, o});
        idle_wait();
    endtask
    // load memory, working, immediate and flags, execute, compare all results
    task automatic dcase(input logic [4:0] o, input logic [7:0] a, mv, wv, xv, input logic [1:0] f);
        logic [17:0] ex;
        ex = model(o, mv, wv, xv, f[1], f[0]);
        wr(`CIE_ADR_MADDR, {8'h00, a});
        wr(`CIE_ADR_WORK, {8'h00, mv});
        run(5'h08);
        wr(`CIE_ADR_WORK, {8'h00, wv});
        wr(`CIE_ADR_IMM, {8'h00, xv});
        wr(`CIE_ADR_STATUS, {14'h0000, f});
        run(o);
        rchk(`CIE_ADR_WORK, {8'h00, ex[9:2]});
        rchk(`CIE_ADR_STATUS, {14'h0000, ex[0], ex[1]});
        run(5'h06);
        rchk(`CIE_ADR_WORK, {8'h00, ex[17:10]});
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rchk(`CIE_ADR_STATUS, 16'h0000);
        // every data opcode once, then random picks
        for (int i = 0; i < 48; i++)
        begin
            r = rnd();
            dcase((i < 18) ? op_tab[i] : op_tab[r[31:8] % 18], r[7:0], r[15:8], r[23:16],
                8'(rnd()), r[25:24]);
        end
        // zero results and carry edges
        dcase(5'h01, 8'h10, 8'h01, 8'h00, 8'h00, 2'b00);
        dcase(5'h04, 8'h11, 8'hff, 8'h00, 8'h00, 2'b10);
        dcase(5'h0a, 8'h12, 8'h00, 8'h00, 8'h00, 2'b10);
        dcase(5'h16, 8'h13, 8'h01, 8'h00, 8'h00, 2'b00);
        dcase(5'h11, 8'h14, 8'h80, 8'h00, 8'h00, 2'b10);
        // jump, nop and undefined opcode
        wr(`CIE_ADR_STATUS, 16'h0003);
        wr(`CIE_ADR_IMM, 16'h1abc);
        run(5'h05);
        rchk(`CIE_ADR_PC, 16'h1abc);
        rchk(`CIE_ADR_STATUS, 16'h0003);
        run(5'h00);
        rchk(`CIE_ADR_PC, 16'h1abd);
        run(5'h1f);
        rchk(`CIE_ADR_PC, 16'h1abe);
        // subroutine exits
        wr(`CIE_ADR_STACK, 16'h0123);
        run(5'h0c);
        rchk(`CIE_ADR_PC, 16'h0123);
        wr(`CIE_ADR_STACK, 16'h0456);
        run(5'h0d);
        rchk(`CIE_ADR_PC, 16'h0456);
        rchk(`CIE_ADR_WORK, 16'h00bc);
        // interrupt exit without and with a pending request
        wr(`CIE_ADR_STACK, 16'h0789);
        run(5'h0e);
        rchk(`CIE_ADR_PC, 16'h0789);
        rchk(`CIE_ADR_STATUS, 16'h0013);
        wr(`CIE_ADR_STACK, 16'h0abc);
        i_irq_pending <= 1'b1;
        run(5'h0e);
        @(posedge i_clk) i_irq_pending <= 1'b0;
        rchk(`CIE_ADR_PC, 16'h0004);
        rchk(`CIE_ADR_STACK, 16'h0abc);
        rchk(`CIE_ADR_STATUS, 16'h0003);
        // write while busy is dropped
        wr(`CIE_ADR_CMD, 16'h0000);
        wr(`CIE_ADR_WORK, 16'h0055);
        idle_wait();
        rchk(`CIE_ADR_WORK, 16'h00bc);
        rchk(`CIE_ADR_STATUS, 16'h0083);
        wr(`CIE_ADR_STATUS, 16'h0080);
        rchk(`CIE_ADR_STATUS, 16'h0000);
        // power down after a watchdog timeout, then wake
        @(posedge i_clk) i_wdt_timeout <= 1'b1;
        @(posedge i_clk) i_wdt_timeout <= 1'b0;
        rchk(`CIE_ADR_STATUS, 16'h0008);
        run(5'h17);
        chk({15'h0000, o_sys_clk_en}, 16'h0000);
        wr(`CIE_ADR_WORK, 16'h0011);
        rchk(`CIE_ADR_STATUS, 16'h00c4);
        @(posedge i_clk) i_wake <= 1'b1;
        @(posedge i_clk) i_wake <= 1'b0;
        #1 chk({15'h0000, o_sys_clk_en}, 16'h0001);
        rchk(`CIE_ADR_WORK, 16'h00bc);
        report_and_stop();
    end
endmodule // tb
